//--- hw/uarsms_cfg.svh
// register offsets, field positions, reset values and timing counts of the serial receiver block
// assumes byte addresses on a 32-bit AHB-Lite slave, one aligned word per register
`ifndef UARSMS_CFG_SVH
`define UARSMS_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UARSMS_OFS_INTCTL 8'h00
`define UARSMS_OFS_PFLAGS 8'h04
`define UARSMS_OFS_PENABLES 8'h08
`define UARSMS_OFS_PPRIO 8'h0C
`define UARSMS_OFS_RXSTAT 8'h10
`define UARSMS_OFS_TXDATA 8'h14
`define UARSMS_OFS_TXSTAT 8'h18
`define UARSMS_OFS_BAUDDIV 8'h1C
`define UARSMS_OFS_RXDATA 8'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define UARSMS_BIT_GLOBAL_IE 7
`define UARSMS_BIT_PERIPH_IE 6
`define UARSMS_BIT_RX_EVT 5
`define UARSMS_BIT_TX_EVT 4
`define UARSMS_BIT_PORT_EN 7
`define UARSMS_BIT_RX_NINE 6
`define UARSMS_BIT_SINGLE_RX 5
`define UARSMS_BIT_CONT_RX 4
`define UARSMS_BIT_ADDR_DET 3
`define UARSMS_BIT_FRAME_ERR 2
`define UARSMS_BIT_OVERRUN 1
`define UARSMS_BIT_NINTH 0
`define UARSMS_BIT_CLK_SRC 7
`define UARSMS_BIT_TX_NINE 6
`define UARSMS_BIT_TX_EN 5
`define UARSMS_BIT_SYNC 4
`define UARSMS_BIT_HIGH_SPEED 2
`define UARSMS_BIT_SHIFT_EMPTY 1
`define UARSMS_BIT_TX_NINTH 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define UARSMS_RST_BYTE 8'h00
`define UARSMS_RST_TXSTAT 8'h02

// ----------------------------------------
// timing counts
// ----------------------------------------
`define UARSMS_SAMPLES_LAST 4'hF
`define UARSMS_VOTE_FIRST 4'h7
`define UARSMS_VOTE_SECOND 4'h8
`define UARSMS_VOTE_LAST 4'h9
`define UARSMS_LOW_SPEED_PRESCALE 2'h3
`define UARSMS_BITS_EIGHT 4'h8
`define UARSMS_BITS_NINE 4'h9

`endif

//--- hw/uarsms_pkg.sv
// types of the serial receiver block: receiver states and the state records of both modules
// assumes uarsms_cfg.svh supplies all numeric constants
package uarsms_pkg;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } uarsms_rxstate_t;

    typedef struct packed {
        logic [7:0] divCnt;
        logic [1:0] preCnt;
        logic tick;
    } uarsms_baud_t;

    typedef struct packed {
        logic globalIntEn;
        logic periphIntEn;
        logic rxIntEn;
        logic txIntEn;
        logic rxPrio;
        logic txPrio;
        logic portEn;
        logic rxNine;
        logic singleRx;
        logic contRx;
        logic addrDet;
        logic clkSrc;
        logic txNine;
        logic transmit_enable;
        logic syncMode;
        logic highSpeed;
        logic txNinth;
        logic [7:0] txData;
        logic [7:0] baudDiv;
        logic [7:0] rxBuf;
        logic rxBufNinth;
        logic rxBufFerr;
        logic rxFull;
        logic overrun;
        uarsms_rxstate_t rxState;
        logic [3:0] sampleCnt;
        logic [3:0] bitIdx;
        logic [8:0] shifter;
        logic [1:0] votes;
        logic wrPend;
        logic [7:0] wrAddr;
        logic [31:0] readData;
        logic timingOut;
    } uarsms_state_t;

endpackage : uarsms_pkg

//--- hw/uarsms_baud_gen.sv
// baud generator: divisor counter with optional divide-by-four prescale, gives a x16 sample tick
// assumes divisor and speed select come straight from software registers
`timescale 1ns/100ps
`include "uarsms_cfg.svh"

module uarsms_baud_gen (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [7:0] divisor,
    input wire logic highSpeed,
    output logic sampleTick
);

    uarsms_pkg::uarsms_baud_t state_ff;
    uarsms_pkg::uarsms_baud_t nxt_state;

    // ----------------------------------------
    // divider
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.tick = 1'b0;
        if (!run)
        begin
            nxt_state.divCnt = 8'h00;
            nxt_state.preCnt = 2'h0;
        end
        else if (state_ff.divCnt >= divisor)
        begin
            // x64 clock in low speed, divided by four to reach x16 [RULE_21]
            nxt_state.divCnt = 8'h00;
            if (highSpeed || state_ff.preCnt == `UARSMS_LOW_SPEED_PRESCALE)
            begin
                nxt_state.preCnt = 2'h0;
                nxt_state.tick = 1'b1;
            end
            else
            begin
                nxt_state.preCnt = state_ff.preCnt + 2'h1;
            end
        end
        else
        begin
            nxt_state.divCnt = state_ff.divCnt + 8'h01;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign sampleTick = state_ff.tick;

endmodule : uarsms_baud_gen

//--- hw/uarsms_top.sv
// serial port receive side with address detect, plus synchronous master mode and pin selection
// assumes an AHB-Lite master doing single word transfers; pins are synchronous to ref_clk
//
// Behaviour
// [RULE_01] receive pin sampled sixteen times per bit; shifter advances once per bit
// [RULE_02] software loads divisor and speed select before receiving
// [RULE_03] async mode when sync bit clear and port enable set
// [RULE_04] ninth-bit enable gives nine data bits; ninth bit shown in receive status
// [RULE_05] characters received only while continuous receive enable is set
// [RULE_06] completed character sets receive flag; request raised when enabled
// [RULE_07] software reads receive status first, then receive data
// [RULE_08] clearing continuous receive enable clears pending receive error
// [RULE_09] software sets global and peripheral enables for interrupt reception
// [RULE_10] receive priority bit picks level; taken only with enables set
// [RULE_11] address detect with nine-bit reception gives multidrop address mode
// [RULE_12] address detect cleared: every character enters buffer and is flagged
// [RULE_13] address detect on: only ninth-bit-one characters kept, rest dropped silently
// [RULE_14] synchronous master is half duplex: receive and transmit exclude each other
// [RULE_15] sync bit in transmit status selects synchronous mode
// [RULE_16] port enable turns the two pins into timing and data lines
// [RULE_17] clock source select makes device master, driving shift clock out
// [RULE_18] unimplemented bits read as zero
// [RULE_19] reserved parallel-port bits kept clear by software
// [RULE_20] frame: start bit, eight or nine data bits lsb first, stop bit
// [RULE_21] baud generator makes x16 or x64 clock by speed select
// [RULE_22] asynchronous operation halts during sleep
`timescale 1ns/100ps
`include "uarsms_cfg.svh"

module uarsms_top (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sleepMode,
    input wire logic receiveDataPinIn,
    output logic receiveDataPinOut,
    output logic receiveDataPinOeN,
    input wire logic transmitTimingPinIn,
    output logic transmitTimingPinOut,
    output logic transmitTimingPinOeN,
    output logic rxIntHigh,
    output logic rxIntLow,
    output logic txInhibit
);

    uarsms_pkg::uarsms_state_t state_ff;
    uarsms_pkg::uarsms_state_t nxt_state;

    logic sampleTick;
    logic asyncMode;
    logic syncMaster;
    logic rxRun;
    logic rxInhibit;
    logic addrPhase;
    logic lineBit;
    logic [7:0] doneData;
    logic doneNinth;
    logic doneKeep;
    logic [3:0] frameBits;

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    assign asyncMode = state_ff.portEn && !state_ff.syncMode; // [RULE_03]
    assign syncMaster = state_ff.portEn && state_ff.syncMode && state_ff.clkSrc; // [RULE_15]
    // no transmit datapath here, so transmit enable stands for transmitting
    assign rxInhibit = syncMaster && state_ff.transmit_enable; // [RULE_14]
    assign txInhibit = syncMaster && (state_ff.contRx || state_ff.singleRx); // [RULE_14]
    // overrun stalls the receiver until continuous receive is cleared
    assign rxRun = asyncMode && state_ff.contRx && !state_ff.overrun &&
                   !sleepMode && !rxInhibit; // [RULE_05] [RULE_22]
    assign frameBits = state_ff.rxNine ? `UARSMS_BITS_NINE : `UARSMS_BITS_EIGHT; // [RULE_04] [RULE_20]
    assign addrPhase = hready && hsel && htrans[1];

    uarsms_baud_gen uarsms_baud_gen_inst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(rxRun || syncMaster),
        .divisor(state_ff.baudDiv),
        .highSpeed(state_ff.highSpeed),
        .sampleTick(sampleTick)
    );

    // ----------------------------------------
    // majority of three mid-bit samples
    // ----------------------------------------
    assign lineBit = (state_ff.votes[1] & state_ff.votes[0]) |
                     (state_ff.votes[1] & receiveDataPinIn) |
                     (state_ff.votes[0] & receiveDataPinIn); // [RULE_01]

    // ----------------------------------------
    // finished character
    // ----------------------------------------
    assign doneData = state_ff.rxNine ? state_ff.shifter[7:0] : state_ff.shifter[8:1];
    assign doneNinth = state_ff.rxNine && state_ff.shifter[8];
    // addresses only while address detect is on in nine-bit mode
    assign doneKeep = !(state_ff.addrDet && state_ff.rxNine && !doneNinth); // [RULE_11] [RULE_12] [RULE_13]

    // ----------------------------------------
    // read mux, unmapped and unimplemented bits as zero
    // ----------------------------------------
    function automatic logic [7:0] readByte(input logic [7:0] addr, input uarsms_pkg::uarsms_state_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            `UARSMS_OFS_INTCTL:
            begin
                v[`UARSMS_BIT_GLOBAL_IE] = s.globalIntEn;
                v[`UARSMS_BIT_PERIPH_IE] = s.periphIntEn;
            end
            `UARSMS_OFS_PFLAGS: v[`UARSMS_BIT_RX_EVT] = s.rxFull; // [RULE_06]
            `UARSMS_OFS_PENABLES:
            begin
                v[`UARSMS_BIT_RX_EVT] = s.rxIntEn;
                v[`UARSMS_BIT_TX_EVT] = s.txIntEn;
            end
            `UARSMS_OFS_PPRIO:
            begin
                v[`UARSMS_BIT_RX_EVT] = s.rxPrio;
                v[`UARSMS_BIT_TX_EVT] = s.txPrio;
            end
            `UARSMS_OFS_RXSTAT:
            begin
                v[`UARSMS_BIT_PORT_EN] = s.portEn;
                v[`UARSMS_BIT_RX_NINE] = s.rxNine;
                v[`UARSMS_BIT_SINGLE_RX] = s.singleRx;
                v[`UARSMS_BIT_CONT_RX] = s.contRx;
                v[`UARSMS_BIT_ADDR_DET] = s.addrDet;
                v[`UARSMS_BIT_FRAME_ERR] = s.rxBufFerr;
                v[`UARSMS_BIT_OVERRUN] = s.overrun;
                v[`UARSMS_BIT_NINTH] = s.rxBufNinth; // [RULE_04]
            end
            `UARSMS_OFS_TXDATA: v = s.txData;
            `UARSMS_OFS_TXSTAT:
            begin
                v[`UARSMS_BIT_CLK_SRC] = s.clkSrc;
                v[`UARSMS_BIT_TX_NINE] = s.txNine;
                v[`UARSMS_BIT_TX_EN] = s.transmit_enable;
                v[`UARSMS_BIT_SYNC] = s.syncMode;
                v[`UARSMS_BIT_HIGH_SPEED] = s.highSpeed;
                v[`UARSMS_BIT_SHIFT_EMPTY] = 1'b1;
                v[`UARSMS_BIT_TX_NINTH] = s.txNinth;
            end
            `UARSMS_OFS_BAUDDIV: v = s.baudDiv;
            `UARSMS_OFS_RXDATA: v = s.rxBuf;
            default: v = 8'h00; // [RULE_18]
        endcase
        return v;
    endfunction : readByte

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        // bus: address phase latched, write done in data phase
        if (hready)
        begin
            nxt_state.wrPend = addrPhase && hwrite;
            nxt_state.wrAddr = haddr[7:0];
        end
        if (addrPhase && !hwrite)
        begin
            nxt_state.readData = {24'h000000, readByte(haddr[7:0], state_ff)};
            // reading the data register empties the buffer
            if (haddr[7:0] == `UARSMS_OFS_RXDATA)
            begin
                nxt_state.rxFull = 1'b0; // [RULE_07]
            end
        end

        if (state_ff.wrPend)
        begin
            unique case (state_ff.wrAddr)
                `UARSMS_OFS_INTCTL:
                begin
                    nxt_state.globalIntEn = hwdata[`UARSMS_BIT_GLOBAL_IE]; // [RULE_09]
                    nxt_state.periphIntEn = hwdata[`UARSMS_BIT_PERIPH_IE];
                end
                `UARSMS_OFS_PENABLES:
                begin
                    // reserved parallel-port positions are not stored [RULE_19]
                    nxt_state.rxIntEn = hwdata[`UARSMS_BIT_RX_EVT];
                    nxt_state.txIntEn = hwdata[`UARSMS_BIT_TX_EVT];
                end
                `UARSMS_OFS_PPRIO:
                begin
                    nxt_state.rxPrio = hwdata[`UARSMS_BIT_RX_EVT];
                    nxt_state.txPrio = hwdata[`UARSMS_BIT_TX_EVT];
                end
                `UARSMS_OFS_RXSTAT:
                begin
                    nxt_state.portEn = hwdata[`UARSMS_BIT_PORT_EN];
                    nxt_state.rxNine = hwdata[`UARSMS_BIT_RX_NINE];
                    nxt_state.singleRx = hwdata[`UARSMS_BIT_SINGLE_RX];
                    nxt_state.contRx = hwdata[`UARSMS_BIT_CONT_RX];
                    nxt_state.addrDet = hwdata[`UARSMS_BIT_ADDR_DET];
                end
                `UARSMS_OFS_TXDATA: nxt_state.txData = hwdata[7:0];
                `UARSMS_OFS_TXSTAT:
                begin
                    nxt_state.clkSrc = hwdata[`UARSMS_BIT_CLK_SRC];
                    nxt_state.txNine = hwdata[`UARSMS_BIT_TX_NINE];
                    nxt_state.transmit_enable = hwdata[`UARSMS_BIT_TX_EN];
                    nxt_state.syncMode = hwdata[`UARSMS_BIT_SYNC];
                    nxt_state.highSpeed = hwdata[`UARSMS_BIT_HIGH_SPEED]; // [RULE_02]
                    nxt_state.txNinth = hwdata[`UARSMS_BIT_TX_NINTH];
                end
                `UARSMS_OFS_BAUDDIV: nxt_state.baudDiv = hwdata[7:0]; // [RULE_02]
                default: nxt_state.wrPend = nxt_state.wrPend;
            endcase
        end

        // shift clock out in master mode, idle high otherwise
        if (!syncMaster || sampleTick)
        begin
            nxt_state.timingOut = !syncMaster || !state_ff.timingOut; // [RULE_17]
        end

        // receiver
        if (!rxRun)
        begin
            nxt_state.rxState = uarsms_pkg::RX_IDLE; // [RULE_05] [RULE_22]
            nxt_state.sampleCnt = 4'h0;
            nxt_state.bitIdx = 4'h0;
        end
        else if (sampleTick)
        begin
            nxt_state.sampleCnt = state_ff.sampleCnt + 4'h1; // [RULE_01]
            if (state_ff.sampleCnt == `UARSMS_VOTE_FIRST)
            begin
                nxt_state.votes[1] = receiveDataPinIn;
            end
            if (state_ff.sampleCnt == `UARSMS_VOTE_SECOND)
            begin
                nxt_state.votes[0] = receiveDataPinIn;
            end
            unique case (state_ff.rxState)
                uarsms_pkg::RX_IDLE:
                begin
                    nxt_state.bitIdx = 4'h0;
                    nxt_state.sampleCnt = receiveDataPinIn ? 4'h0 : 4'h1;
                    if (!receiveDataPinIn)
                    begin
                        nxt_state.rxState = uarsms_pkg::RX_START; // [RULE_20]
                    end
                end
                uarsms_pkg::RX_START:
                begin
                    // a start bit that is high at mid-bit was a glitch
                    if (state_ff.sampleCnt == `UARSMS_VOTE_LAST && lineBit)
                    begin
                        nxt_state.rxState = uarsms_pkg::RX_IDLE;
                        nxt_state.sampleCnt = 4'h0;
                    end
                    else if (state_ff.sampleCnt == `UARSMS_SAMPLES_LAST)
                    begin
                        nxt_state.rxState = uarsms_pkg::RX_DATA;
                    end
                end
                uarsms_pkg::RX_DATA:
                begin
                    if (state_ff.sampleCnt == `UARSMS_VOTE_LAST)
                    begin
                        nxt_state.shifter = {lineBit, state_ff.shifter[8:1]}; // [RULE_01] [RULE_20]
                    end
                    if (state_ff.sampleCnt == `UARSMS_SAMPLES_LAST)
                    begin
                        nxt_state.bitIdx = state_ff.bitIdx + 4'h1;
                        if (state_ff.bitIdx + 4'h1 == frameBits)
                        begin
                            nxt_state.rxState = uarsms_pkg::RX_STOP; // [RULE_04]
                        end
                    end
                end
                uarsms_pkg::RX_STOP:
                begin
                    if (state_ff.sampleCnt == `UARSMS_VOTE_LAST)
                    begin
                        nxt_state.rxState = uarsms_pkg::RX_IDLE;
                        nxt_state.sampleCnt = 4'h0;
                        if (doneKeep)
                        begin
                            // a full buffer loses the new character; set wins over clear
                            if (state_ff.rxFull && nxt_state.rxFull)
                            begin
                                nxt_state.overrun = 1'b1;
                            end
                            else
                            begin
                                nxt_state.rxBuf = doneData;
                                nxt_state.rxBufNinth = doneNinth; // [RULE_04]
                                nxt_state.rxBufFerr = !lineBit;
                                nxt_state.rxFull = 1'b1; // [RULE_06] [RULE_12]
                            end
                        end
                    end
                end
            endcase
        end

        // leaving reception clears a pending overrun; set above still wins
        if (state_ff.wrPend && state_ff.wrAddr == `UARSMS_OFS_RXSTAT && !hwdata[`UARSMS_BIT_CONT_RX] &&
            !(rxRun && sampleTick && state_ff.rxState == uarsms_pkg::RX_STOP))
        begin
            nxt_state.overrun = 1'b0; // [RULE_08]
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state_ff <= '0;
            state_ff.txData <= `UARSMS_RST_BYTE;
            state_ff.baudDiv <= `UARSMS_RST_BYTE;
            state_ff.rxBuf <= `UARSMS_RST_BYTE;
            state_ff.votes <= 2'h3;
            state_ff.timingOut <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_ff.readData;

    // high level needs global enable; low level also needs peripheral enable
    assign rxIntHigh = state_ff.rxFull && state_ff.rxIntEn && state_ff.rxPrio &&
                       state_ff.globalIntEn; // [RULE_06] [RULE_10]
    assign rxIntLow = state_ff.rxFull && state_ff.rxIntEn && !state_ff.rxPrio && state_ff.globalIntEn &&
                      state_ff.periphIntEn; // [RULE_06] [RULE_10]

    // port enable hands both pins to the serial port; transmit path absent, line held idle
    // released pin idles high even in the cycle that master mode is left
    assign transmitTimingPinOut = syncMaster ? state_ff.timingOut : 1'b1;
    assign transmitTimingPinOeN = !(asyncMode || syncMaster); // [RULE_16] [RULE_17]
    assign receiveDataPinOut = 1'b1;
    assign receiveDataPinOeN = 1'b1; // [RULE_16]

endmodule : uarsms_top

//--- testbench/uarsms_monitor.sv
// checker of port relations of the serial receiver top
// assumes a bind to uarsms_top, ports matched by name
`timescale 1ns/100ps
module uarsms_monitor (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic hreadyout,
    input wire logic receiveDataPinOut,
    input wire logic receiveDataPinOeN,
    input wire logic transmitTimingPinOut,
    input wire logic transmitTimingPinOeN,
    input wire logic rxIntHigh,
    input wire logic rxIntLow,
    input wire logic txInhibit
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_rd(a);
        hsel && htrans[1] && !hwrite && hready && haddr[7:0] == a;
    endsequence
    property p_excl; !(rxIntHigh && rxIntLow); endproperty
    property p_dpin; receiveDataPinOeN && receiveDataPinOut; endproperty
    property p_upper; hrdata[31:8] == 24'h0 && !hresp && hreadyout; endproperty
    property p_unmap; s_rd(8'h24) |=> hrdata == 32'h0; endproperty
    property p_txst; s_rd(8'h18) |=> hrdata[3] == 1'h0 && hrdata[1]; endproperty
    property p_idle; transmitTimingPinOeN |-> transmitTimingPinOut; endproperty
    property p_inh; txInhibit |-> !transmitTimingPinOeN; endproperty
    // leaving master may flip the pin in the same edge as release
    property p_tog;
        $changed(transmitTimingPinOut) |-> !transmitTimingPinOeN || !$past(transmitTimingPinOeN);
    endproperty
    a_excl: assert property (p_excl) else $error("both levels raised");
    a_dpin: assert property (p_dpin) else $error("data pin driven");
    a_upper: assert property (p_upper) else $error("upper read bits set");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_txst: assert property (p_txst) else $error("transmit status bits wrong");
    a_idle: assert property (p_idle) else $error("released timing pin low");
    a_inh: assert property (p_inh) else $error("inhibit outside master");
    a_tog: assert property (p_tog) else $error("timing pin moved while released");
endmodule : uarsms_monitor

//--- testbench/uarsms_line_model.sv
// remote serial transmitter driving the receive line
// assumes the bench calls send right after a rising edge
`timescale 1ns/100ps
module uarsms_line_model #(
    parameter int BITCLK = 32
) (
    input wire logic ref_clk,
    output logic line
);
    // ----------------------------------------
    // frame sender
    // ----------------------------------------
    initial line = 1'h1;
    // stp low only where a scenario wants a broken stop bit
    task automatic send(input logic [8:0] d, input logic nine, input logic stp);
        logic [10:0] f;
        f = nine ? {stp, d, 1'h0} : {1'h1, stp, d[7:0], 1'h0};
        for (int i = 0; i < 11; i++)
        begin
            line <= f[i];
            repeat (BITCLK) @(posedge ref_clk);
        end
        line <= 1'h1;
    endtask : send
endmodule : uarsms_line_model

//--- testbench/tb_usart_async_receiver_sync_master_select.sv
// bench of the serial receiver: registers, receive link, sync pins
// assumes divisor 1 with high speed, so one bit is 32 clocks
`timescale 1ns/100ps
module tb_usart_async_receiver_sync_master_select;
    logic ref_clk = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, sleepMode = 1'h0, dph = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rng = 32'hE45C;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] b;
    logic transmitTimingPinIn = 1'h1, receiveDataPinIn, hreadyout, hresp, receiveDataPinOut, receiveDataPinOeN;
    logic transmitTimingPinOut, transmitTimingPinOeN, rxIntHigh, rxIntLow, txInhibit;
    wire hready = hreadyout;
    logic [31:0] expQ[$];
    int fails = 0, cmp_count = 0;
    uarsms_top uarsms_top_inst (.*);
    uarsms_line_model #(.BITCLK(32)) uarsms_line_model_inst (.ref_clk(ref_clk), .line(receiveDataPinIn));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // reads note their expected byte; the watcher compares
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (!hready);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        if (!w)
            expQ.push_back({24'h0, d});
        do @(posedge ref_clk); while (!hready);
    endtask : bus
    task automatic get(input logic [7:0] st, input logic [7:0] d);
        bus(1'h0, 8'h10, st);
        bus(1'h0, 8'h20, d);
    endtask : get
    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // clock, watcher, watchdog, sequence
    // ----------------------------------------
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        if (dph)
            chk("hrdata", hrdata, expQ.pop_front());
        dph <= hsel && htrans[1] && !hwrite && hready;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        print_verdict();
    end
    initial
    begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'h1;
        @(posedge ref_clk);
        bus(1'h0, 8'h18, 8'h02);
        bus(1'h1, 8'h24, 8'h5A);
        bus(1'h0, 8'h24, 8'h00);
        bus(1'h1, 8'h1C, 8'h01);
        bus(1'h1, 8'h18, 8'h04);
        bus(1'h1, 8'h00, 8'hC0);
        bus(1'h1, 8'h08, 8'h20);
        bus(1'h1, 8'h10, 8'h90);
        for (int i = 0; i < 3; i++)
        begin
            b = 8'(rnd());
            uarsms_line_model_inst.send({1'h0, b}, 1'h0, 1'h1);
            chk("rxIntLow", rxIntLow, 1'h1);
            get(8'h90, b);
            chk("rxIntLow", rxIntLow, 1'h0);
        end
        bus(1'h1, 8'h10, 8'hD8);
        uarsms_line_model_inst.send(9'h033, 1'h1, 1'h1);
        chk("rxIntLow", rxIntLow, 1'h0);
        uarsms_line_model_inst.send(9'h1A5, 1'h1, 1'h1);
        get(8'hD9, 8'hA5);
        bus(1'h1, 8'h10, 8'hD0);
        uarsms_line_model_inst.send(9'h0C3, 1'h1, 1'h1);
        get(8'hD0, 8'hC3);
        uarsms_line_model_inst.send(9'h011, 1'h1, 1'h1);
        uarsms_line_model_inst.send(9'h022, 1'h1, 1'h1);
        get(8'hD2, 8'h11);
        bus(1'h1, 8'h10, 8'hC0);
        bus(1'h0, 8'h10, 8'hC0);
        uarsms_line_model_inst.send(9'h044, 1'h1, 1'h1);
        chk("rxIntLow", rxIntLow, 1'h0);
        bus(1'h1, 8'h0C, 8'h20);
        bus(1'h1, 8'h10, 8'h90);
        uarsms_line_model_inst.send(9'h055, 1'h0, 1'h0);
        chk("rxIntHigh", rxIntHigh, 1'h1);
        get(8'h94, 8'h55);
        sleepMode <= 1'h1;
        uarsms_line_model_inst.send(9'h066, 1'h0, 1'h1);
        chk("rxIntHigh", rxIntHigh, 1'h0);
        sleepMode <= 1'h0;
        bus(1'h1, 8'h18, 8'h94);
        @(posedge ref_clk);
        chk("txInhibit", txInhibit, 1'h1);
        chk("timingOeN", transmitTimingPinOeN, 1'h0);
        repeat (6) @(posedge ref_clk);
        bus(1'h1, 8'h18, 8'h14);
        @(posedge ref_clk);
        chk("timingOeN", transmitTimingPinOeN, 1'h1);
        repeat (2) @(posedge ref_clk);
        print_verdict();
    end
endmodule : tb_usart_async_receiver_sync_master_select
bind uarsms_top uarsms_monitor uarsms_monitor_inst (.*);
